// ==== spi_port_pkg.sv ====
// Register map, field positions and state types of the serial port.
// How it works
// - First control word at 0x00, read-write, resets to 0x1C000000.
// - Second control word at 0x04, read-write, resets to zero.
// - Data port at 0x08 exchanges frames, resets to zero.
// - Status word at 0x0C is read-only, reads 0x00000003 after reset.
// - Mask at 0x14 read-write; raw 0x18 and masked 0x1C read-only.
// - Interrupt clear word at 0x20 is write-only and reads zero.
// - DMA request control at 0x24 is read-write, cleared on reset.
// - Receive frame count at 0x28 is read-write, zero after reset.
// - Transmit frame count at 0x30 is read-write, zero after reset.
// - Test control at 0x80 and test data at 0x8C, read-write, zero.
// - Frame length is frame bits field 4:0 plus one.
// - Standard format: bit 6 sets the idle serial clock level.
// - Standard format: bit 7 selects the clock phase.
// - Bit rate is clock over prescale divisor times one plus rate.
// - Format field 0 is four-wire standard, 2 is three-wire.
// - Role select 0 makes the port master, 1 makes it slave.
// - Writing 1 to a clear bit drops timeout, overrun, underrun.
package spi_port_pkg;

  localparam logic [7:0] OFF_CR0   = 8'h00;
  localparam logic [7:0] OFF_CR1   = 8'h04;
  localparam logic [7:0] OFF_DATA  = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0c;
  localparam logic [7:0] OFF_PRE   = 8'h10;
  localparam logic [7:0] OFF_MASK  = 8'h14;
  localparam logic [7:0] OFF_RAW   = 8'h18;
  localparam logic [7:0] OFF_MIS   = 8'h1c;
  localparam logic [7:0] OFF_ICR   = 8'h20;
  localparam logic [7:0] OFF_DMA   = 8'h24;
  localparam logic [7:0] OFF_RXCNT = 8'h28;
  localparam logic [7:0] OFF_DUMMY = 8'h2c;
  localparam logic [7:0] OFF_TXCNT = 8'h30;
  localparam logic [7:0] OFF_TCTL  = 8'h80;
  localparam logic [7:0] OFF_TVAL  = 8'h8c;

  localparam logic [31:0] RST_CR0  = 32'h1c000000;
  localparam logic [31:0] RST_STAT = 32'h00000003;
  localparam logic [31:0] RST_ZERO = 32'h00000000;

  localparam int FLD_CPOL    = 6;
  localparam int FLD_CPHA    = 7;
  localparam int FLD_RATE_LO = 8;
  localparam int FLD_FMT_LO  = 21;
  localparam int FLD_EN      = 1;
  localparam int FLD_ROLE    = 2;
  localparam int FLD_SOD     = 3;

  localparam int ST_TFE = 0;
  localparam int ST_TNF = 1;
  localparam int ST_RNE = 2;
  localparam int ST_BSY = 4;

  localparam int IRQ_OVR = 0;
  localparam int IRQ_TMO = 1;
  localparam int IRQ_UDR = 2;

  localparam logic [1:0] FMT_STD   = 2'h0;
  localparam logic [1:0] FMT_WIRE3 = 2'h2;

  // 32 bit periods of the serial clock, counted in half periods
  localparam logic [6:0] TMO_HALF = 7'h40;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN  = 3'b010,
    S_SLV  = 3'b100
  } mode_t;

  typedef struct packed {
    logic [7:0] prescale;
    logic [7:0] rate;
  } div_cfg_t;

  typedef struct packed {
    logic [14:0] cnt;
    logic        tick;
  } div_st_t;

  typedef struct packed {
    logic [31:0] cr0;
    logic [31:0] cr1;
    logic [31:0] pre;
    logic [31:0] irq_mask;
    logic [2:0]  raw_irq_flags;
    logic [31:0] dma;
    logic [31:0] rxcnt;
    logic [31:0] dummy;
    logic [31:0] txcnt;
    logic [31:0] tctl;
    logic [31:0] tval;
    logic [31:0] txd;
    logic        tx_full;
    logic [31:0] rxd;
    logic        rx_full;
    logic [31:0] txs;
    logic [31:0] rxs;
    logic [6:0]  cnt;
    logic [6:0]  tocnt;
    mode_t       mode;
    logic        sck;
    logic        mosi;
    logic        cs_n;
    logic        miso;
    logic        miso_oe;
    logic        sck_prev;
    logic        cs_prev;
    logic        ack;
    logic [31:0] dat;
    logic        irq;
  } st_t;

  function automatic logic [5:0] frame_len(input logic [4:0] f);
    return {1'b0, f} + 6'h01;
  endfunction

  function automatic logic [31:0] len_mask(input logic [5:0] n);
    return 32'hffffffff >> (6'h20 - n);
  endfunction

  function automatic logic [31:0] merge_sel(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ==== bit_rate_div.sv ====
// Half-period tick generator for the serial clock.
`timescale 1ns/10ps
module bit_rate_div
  import spi_port_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_rst_n,
  input  wire logic     i_run,
  input  wire logic     i_restart,
  input  wire div_cfg_t i_cfg,
  output logic          o_tick
);

  div_st_t     st;
  div_st_t     next_st;
  logic [6:0]  half;
  logic [14:0] load;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    // Divisor zero would stall the clock, so it acts as two
    half = (i_cfg.prescale[7:1] == 7'h00) ? 7'h01 : i_cfg.prescale[7:1];
    load = 15'(half * ({1'b0, i_cfg.rate} + 9'h001) - 16'h0001);
    if (!i_run || i_restart) begin
      next_st.cnt = load;
    end else if (st.cnt == 15'h0000) begin
      next_st.tick = 1'b1;
      next_st.cnt = load;
    end else begin
      next_st.cnt = st.cnt - 15'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_tick_due: assert property (
    st.cnt == 15'h0000 && i_run && !i_restart |=> o_tick)
    else $error("tick missing at end of count");

  a_tick_cause: assert property (
    o_tick |-> $past(st.cnt) == 15'h0000 && $past(i_run))
    else $error("tick without expired count");

endmodule

// ==== spi_port.sv ====
// Top: Wishbone register file and serial shift engine of the port.
`timescale 1ns/10ps
module spi_port
  import spi_port_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic [31:0]      O_WB_DAT,
  output logic             O_WB_ACK,
  input  wire logic        I_MISO,
  input  wire logic        I_SCK,
  input  wire logic        I_CS_N,
  input  wire logic        I_MOSI,
  output logic             O_SCK,
  output logic             O_CS_N,
  output logic             O_MOSI,
  output logic             O_MISO,
  output logic             O_MISO_OE,
  output logic             O_IRQ
);

  st_t         st;
  st_t         next_st;
  div_cfg_t    cfg;
  logic        tick;
  logic        restart;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        hit;
  logic        en;
  logic        slave;
  logic [1:0]  fmt;
  logic        cpol;
  logic        cpha;
  logic [5:0]  n;
  logic        ev;
  logic        lead;
  logic        smp;
  logic        bit_out;
  logic        done;
  logic        set_ovr;
  logic        set_tmo;
  logic        set_udr;
  logic [31:0] status;
  logic [31:0] wd;
  logic [31:0] clr;
  logic [31:0] shifted;

  ////////////////////////////////////////////////////////////////////
  // Bit-rate divider

  // One driver for the whole divider setting
  assign cfg = {st.pre[7:0], st.cr0[FLD_RATE_LO +: 8]};

  bit_rate_div u_div (
    .i_clk     (I_CLK),
    .i_rst_n   (I_RST_N),
    .i_run     (en),
    .i_restart (restart),
    .i_cfg     (cfg),
    .o_tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    restart = 1'b0;
    ev = 1'b0;
    lead = 1'b0;
    done = 1'b0;
    hit = 1'b0;
    set_ovr = 1'b0;
    set_tmo = 1'b0;
    set_udr = 1'b0;
    acc = I_WB_CYC & I_WB_STB & ~st.ack;
    wr = acc & I_WB_WE;
    rd = acc & ~I_WB_WE;
    en = st.cr1[FLD_EN];
    slave = st.cr1[FLD_ROLE];
    fmt = st.cr0[FLD_FMT_LO +: 2];
    // Polarity and phase apply to the standard format only
    cpol = (fmt == FMT_STD) & st.cr0[FLD_CPOL];
    cpha = (fmt == FMT_STD) & st.cr0[FLD_CPHA];
    n = frame_len(st.cr0[4:0]);
    shifted = st.txd << (6'h20 - n);
    wd = merge_sel(st.txd, I_WB_DAT, I_WB_SEL);
    clr = merge_sel(RST_ZERO, I_WB_DAT, I_WB_SEL);
    status = RST_ZERO;
    status[ST_TFE] = ~st.tx_full;
    status[ST_TNF] = ~st.tx_full;
    status[ST_RNE] = st.rx_full;
    status[ST_BSY] = st.mode != S_IDLE;
    next_st.sck_prev = I_SCK;
    next_st.cs_prev = I_CS_N;

    // Shift engine; runs before the bus so a new write is not lost
    case (st.mode)
      S_IDLE: begin
        next_st.sck = cpol;
        next_st.cs_n = 1'b1;
        if (en && !slave && st.tx_full) begin
          restart = 1'b1;
          next_st.mode = S_RUN;
          next_st.cs_n = 1'b0;
          next_st.cnt = 7'h00;
          next_st.txs = shifted;
          next_st.tx_full = 1'b0;
          next_st.mosi = cpha ? 1'b0 : shifted[31];
        end else if (en && slave && st.cs_prev && !I_CS_N) begin
          next_st.mode = S_SLV;
          next_st.cnt = 7'h00;
          if (st.tx_full) begin
            next_st.txs = shifted;
            next_st.tx_full = 1'b0;
          end else begin
            // Nothing queued: the frame goes out as zeros
            next_st.txs = RST_ZERO;
            set_udr = 1'b1;
          end
          next_st.miso = cpha ? 1'b0 : next_st.txs[31];
        end
      end
      S_RUN: begin
        if (!en) begin
          next_st.mode = S_IDLE;
          next_st.cs_n = 1'b1;
          next_st.sck = cpol;
        end else if (tick) begin
          ev = 1'b1;
          lead = ~st.cnt[0];
          next_st.sck = ~st.sck;
          next_st.cnt = st.cnt + 7'h01;
          if (st.cnt == 7'({1'b0, n, 1'b0} - 8'h01)) begin
            done = 1'b1;
            next_st.mode = S_IDLE;
            next_st.cs_n = 1'b1;
            next_st.sck = cpol;
          end
        end
      end
      S_SLV: begin
        if (!en || I_CS_N) begin
          next_st.mode = S_IDLE;
        end else if (I_SCK != st.sck_prev) begin
          ev = 1'b1;
          lead = I_SCK != cpol;
        end
      end
      default: begin
        next_st.mode = S_IDLE;
      end
    endcase

    smp = lead ^ cpha;
    bit_out = cpha ? st.txs[31] : st.txs[30];
    if (ev && smp) begin
      next_st.rxs = {st.rxs[30:0], slave ? I_MOSI : I_MISO};
      if (st.mode == S_SLV) begin
        next_st.cnt = st.cnt + 7'h01;
        if (st.cnt == 7'({1'b0, n} - 7'h01)) begin
          done = 1'b1;
          next_st.mode = S_IDLE;
        end
      end
    end
    if (ev && !smp) begin
      next_st.txs = {st.txs[30:0], 1'b0};
      if (slave) begin
        next_st.miso = bit_out;
      end else begin
        next_st.mosi = bit_out;
      end
    end

    // Register writes
    if (wr) begin
      case (I_WB_ADR)
        OFF_CR0:   next_st.cr0   = merge_sel(st.cr0, I_WB_DAT, I_WB_SEL);
        OFF_CR1:   next_st.cr1   = merge_sel(st.cr1, I_WB_DAT, I_WB_SEL);
        OFF_DATA: begin
          next_st.txd = wd;
          next_st.tx_full = 1'b1;
        end
        OFF_PRE:   next_st.pre   = merge_sel(st.pre, I_WB_DAT, I_WB_SEL);
        OFF_MASK:  next_st.irq_mask  = merge_sel(st.irq_mask, I_WB_DAT, I_WB_SEL);
        OFF_ICR:   next_st.raw_irq_flags   = st.raw_irq_flags & ~clr[2:0];
        OFF_DMA:   next_st.dma   = merge_sel(st.dma, I_WB_DAT, I_WB_SEL);
        OFF_RXCNT: next_st.rxcnt = merge_sel(st.rxcnt, I_WB_DAT, I_WB_SEL);
        OFF_DUMMY: next_st.dummy = merge_sel(st.dummy, I_WB_DAT, I_WB_SEL);
        OFF_TXCNT: next_st.txcnt = merge_sel(st.txcnt, I_WB_DAT, I_WB_SEL);
        OFF_TCTL:  next_st.tctl  = merge_sel(st.tctl, I_WB_DAT, I_WB_SEL);
        OFF_TVAL:  next_st.tval  = merge_sel(st.tval, I_WB_DAT, I_WB_SEL);
        default: begin
        end
      endcase
    end

    // Register reads; status, raw and masked words ignore writes
    if (acc) begin
      next_st.ack = 1'b1;
      next_st.dat = RST_ZERO;
    end
    if (rd) begin
      hit = 1'b1;
      case (I_WB_ADR)
        OFF_CR0:   next_st.dat = st.cr0;
        OFF_CR1:   next_st.dat = st.cr1;
        OFF_DATA: begin
          next_st.dat = st.rxd;
          next_st.rx_full = 1'b0;
        end
        OFF_STAT:  next_st.dat = status;
        OFF_PRE:   next_st.dat = st.pre;
        OFF_MASK:  next_st.dat = st.irq_mask;
        OFF_RAW:   next_st.dat = {29'h0, st.raw_irq_flags};
        OFF_MIS:   next_st.dat = {29'h0, st.raw_irq_flags & st.irq_mask[2:0]};
        OFF_DMA:   next_st.dat = st.dma;
        OFF_RXCNT: next_st.dat = st.rxcnt;
        OFF_DUMMY: next_st.dat = st.dummy;
        OFF_TXCNT: next_st.dat = st.txcnt;
        OFF_TCTL:  next_st.dat = st.tctl;
        OFF_TVAL:  next_st.dat = st.tval;
        default:   hit = 1'b0;
      endcase
    end

    // Frame capture after the read, so a new frame beats the clear
    if (done) begin
      if (next_st.rx_full) begin
        set_ovr = 1'b1; // Held word kept, new one dropped
      end else begin
        next_st.rxd = next_st.rxs & len_mask(n);
        next_st.rx_full = 1'b1;
      end
    end

    // Unread word and silence for 32 bit periods
    if (!next_st.rx_full || done) begin
      next_st.tocnt = 7'h00;
    end else if (tick && st.tocnt != TMO_HALF) begin
      next_st.tocnt = st.tocnt + 7'h01;
      set_tmo = (st.tocnt + 7'h01) == TMO_HALF;
    end

    // Sets applied last so they win over a same-cycle clear
    if (set_ovr) begin
      next_st.raw_irq_flags[IRQ_OVR] = 1'b1;
    end
    if (set_tmo) begin
      next_st.raw_irq_flags[IRQ_TMO] = 1'b1;
    end
    if (set_udr) begin
      next_st.raw_irq_flags[IRQ_UDR] = 1'b1;
    end
    next_st.irq = |(next_st.raw_irq_flags & next_st.irq_mask[2:0]);
    next_st.miso_oe = (next_st.mode == S_SLV) & ~st.cr1[FLD_SOD];
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st <= '0;
      st.cr0 <= RST_CR0;
      st.mode <= S_IDLE;
      st.cs_n <= 1'b1;
      st.cs_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign O_WB_DAT  = st.dat;
  assign O_WB_ACK  = st.ack;
  assign O_SCK     = st.sck;
  assign O_CS_N    = st.cs_n;
  assign O_MOSI    = st.mosi;
  assign O_MISO    = st.miso;
  assign O_MISO_OE = st.miso_oe;
  assign O_IRQ     = st.irq;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  a_cr0_reset: assert property (
    $rose(I_RST_N) |-> st.cr0 == RST_CR0)
    else $error("first control word wrong after reset");

  a_cr1_reset: assert property (
    $rose(I_RST_N) |-> st.cr1 == RST_ZERO && st.txd == RST_ZERO)
    else $error("second control word or data not zero");

  a_status_reset: assert property (
    $rose(I_RST_N) |-> status == RST_STAT)
    else $error("status word wrong after reset");

  a_unmapped_zero: assert property (
    rd && !hit |=> O_WB_ACK && O_WB_DAT == RST_ZERO)
    else $error("unassigned offset did not read zero");

  a_irq_masked: assert property (
    O_IRQ == |(st.raw_irq_flags & st.irq_mask[2:0]))
    else $error("interrupt line not raw AND mask");

  a_clear_overrun: assert property (
    wr && I_WB_ADR == OFF_ICR && I_WB_SEL[0] && I_WB_DAT[IRQ_OVR]
      && !set_ovr |=> !st.raw_irq_flags[IRQ_OVR])
    else $error("overrun flag survived its clear");

  a_idle_clock: assert property (
    // A write to the first control word moves the level one cycle late
    st.mode == S_IDLE && $stable(st.cr0) && fmt == FMT_STD
      && !(wr && I_WB_ADR == OFF_CR0)
      |=> O_SCK == st.cr0[FLD_CPOL])
    else $error("idle clock level wrong");

  a_slave_quiet: assert property (
    st.cr1[FLD_ROLE] && st.mode == S_IDLE |=> st.mode != S_RUN)
    else $error("slave role started a master frame");

  a_data_queued: assert property (
    wr && I_WB_ADR == OFF_DATA |=> st.tx_full && st.txd == $past(wd))
    else $error("data write not queued");

  a_frame_edges: assert property (
    done && st.mode == S_RUN |-> O_SCK != cpol && st.cnt[0])
    else $error("master frame ended on wrong edge");

  c_master_frame: cover property (done && st.mode == S_RUN);
  c_slave_frame: cover property (done && st.mode == S_SLV);
  c_overrun: cover property (set_ovr);
  c_timeout: cover property (set_tmo);
  c_underrun: cover property (set_udr);

endmodule

// ==== spi_slave_model.sv ====
// Behavioural serial slave facing the master side of the port.
`timescale 1ns/10ps
module spi_slave_model (
  input  wire logic        i_clk,
  input  wire logic        i_sck,
  input  wire logic        i_cs_n,
  input  wire logic        i_mosi,
  input  wire logic        i_cpol,
  input  wire logic        i_cpha,
  input  wire logic [5:0]  i_len,
  input  wire logic [31:0] i_tx,
  output logic             o_miso,
  output logic [31:0]      o_rx,
  output logic [6:0]       o_edges,
  output logic [15:0]      o_half
);
  logic        sck_q = 1'b0;
  logic        cs_q  = 1'b1;
  logic [31:0] sh    = 32'h0;
  logic [15:0] gap   = 16'h0;
  logic        lead;
  // Leaving the idle level marks a leading edge
  assign lead = (sck_q == i_cpol);
  initial begin
    o_miso  = 1'b0;
    o_rx    = 32'h0;
    o_edges = 7'h0;
    o_half  = 16'h0;
  end
  always @(posedge i_clk) begin
    sck_q <= i_sck;
    cs_q  <= i_cs_n;
    gap   <= gap + 16'h0001;
    // Released line has no pull: keep it moving
    if (i_cs_n) begin
      o_miso <= ~o_miso;
    end
    if (cs_q && !i_cs_n) begin
      sh      <= i_tx << (6'h20 - i_len);
      o_miso  <= i_tx[i_len - 6'h01];
      o_rx    <= 32'h0;
      o_edges <= 7'h0;
    end else if (!cs_q && i_sck != sck_q) begin
      o_edges <= o_edges + 7'h01;
      o_half  <= gap;
      gap     <= 16'h0001;
      if (lead != i_cpha) begin
        o_rx <= {o_rx[30:0], i_mosi};
      end else if (o_edges != 7'h0) begin
        sh     <= sh << 1;
        o_miso <= sh[30];
      end
    end
  end
endmodule

// ==== tb_top.sv ====
// Self-checking bench: registers, master frames, flags, slave role.
`timescale 1ns/10ps
module tb_top;
  import spi_port_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, p_rx;
  logic        ack, miso, sck, cs_n, mosi, s_miso, s_oe, irq;
  logic        s_sck = 1'b0, s_cs_n = 1'b1, s_mosi = 1'b0;
  logic        p_cpol = 1'b0, p_cpha = 1'b0;
  logic [5:0]  p_len = 6'h08;
  logic [31:0] p_tx = 32'h0, lf = 32'h000168f0;
  logic [6:0]  p_edges;
  logic [15:0] p_half;
  int          error_cnt = 0, n_tests = 0, cycles = 0;
  logic [7:0]  offs [17] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h24, 8'h28,
    8'h2c, 8'h30, 8'h80, 8'h8c, 8'h08, 8'h0c, 8'h18, 8'h1c, 8'h20,
    8'h34, 8'h84};
  logic [4:0]  fc [4] = '{5'h03, 5'h1f, 5'h07, 5'h0f};

  always #10 clk = ~clk;

  spi_port dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_MISO(miso),
    .I_SCK(s_sck), .I_CS_N(s_cs_n), .I_MOSI(s_mosi), .O_SCK(sck),
    .O_CS_N(cs_n), .O_MOSI(mosi), .O_MISO(s_miso), .O_MISO_OE(s_oe),
    .O_IRQ(irq));

  spi_slave_model peer_u (.i_clk(clk), .i_sck(sck), .i_cs_n(cs_n),
    .i_mosi(mosi), .i_cpol(p_cpol), .i_cpha(p_cpha), .i_len(p_len),
    .i_tx(p_tx), .o_miso(miso), .o_rx(p_rx), .o_edges(p_edges),
    .o_half(p_half));

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] msk(input logic [5:0] n);
    return 32'hffffffff >> (6'h20 - n);
  endfunction
  // Half period in clocks: divisor over two times one plus rate
  function automatic logic [31:0] half(input int p, input int r);
    return ((p / 2 < 1) ? 1 : p / 2) * (1 + r);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_cs(input logic lv);
    int n;
    n = 0;
    while (cs_n !== lv && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n == 2000) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, cs_n, lv);
    end
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q, e, t;
    logic [5:0]  ln;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 17; i++) begin
      wb(1'b0, offs[i], 32'h0, 4'hf, q);
      e = (i == 0) ? RST_CR0 : (offs[i] == OFF_STAT) ? RST_STAT : RST_ZERO;
      chk(q, e);
    end
    for (int i = 0; i < 10; i++) begin
      lf = nxt(lf);
      // Divisor kept even and inside 2..254
      e = (offs[i] == OFF_PRE) ? {24'h0, lf[7:2], 2'b10} : lf;
      wb(1'b1, offs[i], e, 4'hf, q);
      wb(1'b0, offs[i], 32'h0, 4'hf, q);
      chk(q, e);
    end
    wb(1'b1, OFF_CR1, 32'h0, 4'hf, q);
    for (int i = 11; i < 17; i++) begin
      lf = nxt(lf);
      wb(1'b1, offs[i], lf, 4'hf, q);
      wb(1'b0, offs[i], 32'h0, 4'hf, q);
      chk(q, (offs[i] == OFF_STAT) ? RST_STAT : RST_ZERO);
    end
    wb(1'b1, OFF_DMA, 32'h0, 4'hf, q);
    wb(1'b1, OFF_DMA, lf, 4'h2, q);
    wb(1'b0, OFF_DMA, 32'h0, 4'hf, q);
    chk(q, {16'h0, lf[15:8], 8'h0});
    // Four clock modes, four lengths, rate 0..3
    wb(1'b1, OFF_PRE, 32'h4, 4'hf, q);
    for (int m = 0; m < 4; m++) begin
      ln = {1'b0, fc[m]} + 6'h01;
      wb(1'b1, OFF_CR0, {16'h0, m[7:0], m[1], m[0], 1'b0, fc[m]}, 4'hf, q);
      lf = nxt(lf);
      p_cpol <= m[0];
      p_cpha <= m[1];
      p_len <= ln;
      p_tx <= lf;
      repeat (2) @(posedge clk);
      chk({31'h0, sck}, {31'h0, m[0]});
      wb(1'b1, OFF_CR1, 32'h2, 4'hf, q);
      lf = nxt(lf);
      t = lf & msk(ln);
      wb(1'b1, OFF_DATA, t, 4'hf, q);
      wait_cs(1'b0);
      wait_cs(1'b1);
      repeat (2) @(posedge clk);
      chk(p_rx, t);
      chk({25'h0, p_edges}, {25'h0, ln, 1'b0});
      chk({16'h0, p_half}, half(4, m));
      wb(1'b0, OFF_DATA, 32'h0, 4'hf, q);
      chk(q, p_tx & msk(ln));
      wb(1'b1, OFF_CR1, 32'h0, 4'hf, q);
    end
    // Two frames unread: second one overruns and is dropped
    wb(1'b1, OFF_CR0, 32'h00000107, 4'hf, q);
    p_cpol <= 1'b0;
    p_cpha <= 1'b0;
    p_len <= 6'h08;
    wb(1'b1, OFF_CR1, 32'h2, 4'hf, q);
    e = p_tx & 32'hff;
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, OFF_DATA, 32'h5a, 4'hf, q);
      wait_cs(1'b0);
      wait_cs(1'b1);
      p_tx <= 32'ha5;
      repeat (2) @(posedge clk);
    end
    wb(1'b0, OFF_RAW, 32'h0, 4'hf, q);
    chk(q & 32'h1, 32'h1);
    wb(1'b1, OFF_MASK, 32'h1, 4'hf, q);
    wb(1'b0, OFF_MIS, 32'h0, 4'hf, q);
    chk(q, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wb(1'b0, OFF_DATA, 32'h0, 4'hf, q);
    chk(q, e);
    wb(1'b1, OFF_ICR, 32'h1, 4'hf, q);
    wb(1'b0, OFF_RAW, 32'h0, 4'hf, q);
    chk(q & 32'h1, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Slave role, 4-bit frame, nothing queued to send
    wb(1'b1, OFF_CR1, 32'h0, 4'hf, q);
    wb(1'b1, OFF_CR0, 32'h00000003, 4'hf, q);
    wb(1'b1, OFF_CR1, 32'h6, 4'hf, q);
    lf = nxt(lf);
    s_cs_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({30'h0, s_oe, cs_n}, 32'h3);
    for (int b = 3; b >= 0; b--) begin
      s_mosi <= lf[b];
      repeat (3) @(posedge clk);
      chk({31'h0, s_miso}, 32'h0);
      s_sck <= 1'b1;
      repeat (3) @(posedge clk);
      s_sck <= 1'b0;
      repeat (3) @(posedge clk);
    end
    s_cs_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, OFF_DATA, 32'h0, 4'hf, q);
    chk(q, {28'h0, lf[3:0]});
    wb(1'b0, OFF_RAW, 32'h0, 4'hf, q);
    chk(q & 32'h4, 32'h4);
    wb(1'b1, OFF_ICR, 32'h4, 4'hf, q);
    wb(1'b0, OFF_RAW, 32'h0, 4'hf, q);
    chk(q & 32'h4, 32'h0);
    // Queued word goes out MSB first on the slave output
    t = nxt(lf);
    wb(1'b1, OFF_DATA, t, 4'hf, q);
    s_cs_n <= 1'b0;
    repeat (3) @(posedge clk);
    for (int b = 3; b >= 0; b--) begin
      s_mosi <= lf[b];
      repeat (3) @(posedge clk);
      chk({31'h0, s_miso}, {31'h0, t[b]});
      s_sck <= 1'b1;
      repeat (3) @(posedge clk);
      s_sck <= 1'b0;
      repeat (3) @(posedge clk);
    end
    s_cs_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, OFF_DATA, 32'h0, 4'hf, q);
    chk(q, {28'h0, lf[3:0]});
    wb(1'b0, OFF_RAW, 32'h0, 4'hf, q);
    chk(q & 32'h4, 32'h0);
    wb(1'b1, OFF_CR1, 32'he, 4'hf, q);
    s_cs_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, s_oe}, 32'h0);
    s_cs_n <= 1'b1;
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule
